// File: operand_address_and_stack_unit.sv
// stack sequencer, operand address generator and APB register slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
// How it works
// - pointer steps down before each pushed byte, up after each popped byte
// - interrupt pushes PC and flags; interrupt return pops both back
// - call saves PC on the stack; subroutine return restores it
// - stack pointer is an 8-bit read/write register at location D9H
// - reset leaves the stack pointer undefined until software writes it
// - pointer arithmetic wraps modulo 256, 00H steps down to FFH
// - pointer always addresses the most recently pushed byte
// - working mode picks the operand with a 4-bit field in a 16-byte window
// - indirect mode uses an 8-bit register or a 16-bit pair as address
// - indexed register access adds instruction base to working-register offset
// - short memory offset is sign-extended, -128 to +127
// - indexed memory adds 8- or 16-bit offset to a working pair base
// - indexed file access only for load; memory indexing only for table loads
// - direct jump and call load the 16-bit address into the PC
// - table and external loads accept a direct 16-bit address
// - relative mode adds signed displacement to the already advanced PC
// - relative mode is accepted only for the relative jump
// - immediate mode takes the operand from the instruction, no access
// - register pairs: even address holds high byte, odd holds low byte
// - working window sits at C0H to CFH regardless of page
module operand_address_and_stack_unit
  import addr_stack_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire op_t cmdOp,
  input wire mode_t cmdMode,
  input wire class_t cmdClass,
  input wire logic [7:0] cmdReg,
  input wire logic cmdWorking,
  input wire logic cmdPair,
  input wire logic cmdLong,
  input wire logic [15:0] cmdImm,
  input wire logic [15:0] pcIn,
  input wire logic [7:0] flagsIn,
  input wire logic [7:0] pushData,
  output logic [7:0] rfAddr,
  output logic rfWrEn,
  output logic [7:0] rfWrData,
  output logic rfRdEn,
  input wire logic [7:0] rfRdData,
  output logic doneValid,
  output logic [15:0] effAddr,
  output logic [7:0] operand,
  output logic [7:0] popData,
  output logic pcLoad,
  output logic [15:0] pcOut,
  output logic flagsLoad,
  output logic [7:0] flagsOut,
  output logic modeError
);

  state_t state_q;
  op_t op_q;
  mode_t mode_q;
  class_t class_q;
  logic [7:0] buf_q [3];
  logic [1:0] last_q;
  logic [1:0] idx_q;
  logic [23:0] popAcc_q;
  logic [15:0] fetchAcc_q;
  logic [7:0] rdBase_q;
  logic [7:0] regAddr_q;
  logic pair_q;
  logic rfIdx_q;
  logic long_q;
  logic [15:0] imm_q;
  logic [15:0] pc_q;
  logic err_q;
  logic errSticky_q;
  logic [31:0] prdata_q;
  logic busy;
  logic accept;
  logic illegal;
  logic [7:0] regAddr;
  logic [7:0] pairAddr;
  logic [7:0] workAddr;
  logic ptrSel;
  logic [15:0] fetched;
  logic statusSel;
  logic access;
  logic [31:0] readMux;
  logic [15:0] idxOffset;
  logic [15:0] idxSum;
  logic [15:0] relSum;
  logic isJumpClass;
  logic isTableClass;

  sp_ctrl_if spc ();

  stack_pointer u_stackPtr (
    .clk(clk),
    .ctl(spc.owner)
  );

  // ==========================================
  // operand address helpers
  assign workAddr = {WORK_BASE, cmdReg[3:0]};
  assign regAddr = cmdWorking ? workAddr : cmdReg;
  assign pairAddr = {regAddr[7:1], 1'b0};
  assign isTableClass = (cmdClass == C_PLOAD) || (cmdClass == C_ELOAD);
  assign isJumpClass = (cmdClass == C_AJUMP) || (cmdClass == C_CALL);

  always_comb
  begin
    illegal = 1'b0;
    if (cmdOp == OP_EA)
    begin
      if (cmdMode == M_IDX)
      begin
        illegal = !((cmdClass == C_LOAD) || isTableClass);
      end
      else if (cmdMode == M_REL)
      begin
        illegal = (cmdClass != C_RJUMP);
      end
      else if (cmdMode == M_DIRECT)
      begin
        illegal = !(isJumpClass || isTableClass);
      end
    end
  end

  assign idxOffset = long_q ? imm_q : 16'($signed(imm_q[7:0]));

  // last fetched byte is still on the read port in the done cycle
  assign fetched = {fetchAcc_q[7:0], rfRdData};

  offset_adder #(.OW(16)) u_idxAdd (
    .base(fetched),
    .offset(idxOffset),
    .sum(idxSum)
  );

  offset_adder #(.OW(8)) u_relAdd (
    .base(pc_q),
    .offset(imm_q[7:0]),
    .sum(relSum)
  );

  // ==========================================
  // sequencer
  assign busy = (state_q != S_IDLE);
  assign cmdReady = !busy;
  assign accept = cmdValid && !busy;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      idx_q <= 2'h0;
      last_q <= 2'h0;
      err_q <= 1'b0;
    end
    else
    begin
      err_q <= accept && illegal;
      case (state_q)
        S_IDLE:
        begin
          idx_q <= 2'h0;
          if (accept && !illegal)
          begin
            case (cmdOp)
              OP_PUSH:
              begin
                state_q <= S_PUSH;
                last_q <= LAST_ONE;
              end
              OP_CALL:
              begin
                state_q <= S_PUSH;
                last_q <= LAST_TWO;
              end
              OP_INTR:
              begin
                state_q <= S_PUSH;
                last_q <= LAST_THREE;
              end
              OP_POP:
              begin
                state_q <= S_POPRD;
                last_q <= LAST_ONE;
              end
              OP_SUBRTN:
              begin
                state_q <= S_POPRD;
                last_q <= LAST_TWO;
              end
              OP_INTRTN:
              begin
                state_q <= S_POPRD;
                last_q <= LAST_THREE;
              end
              default:
              begin
                if ((cmdMode == M_IND) || (cmdMode == M_IDX))
                begin
                  state_q <= S_FETCH;
                end
                else
                begin
                  state_q <= S_DONE;
                end
                last_q <= ((cmdMode == M_IDX && isTableClass) || (cmdMode == M_IND && cmdPair))
                  ? LAST_TWO : LAST_ONE;
              end
            endcase
          end
        end
        S_PUSH:
        begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == last_q)
          begin
            state_q <= S_DONE;
          end
        end
        S_POPRD:
        begin
          state_q <= S_POPCAP;
        end
        S_POPCAP:
        begin
          idx_q <= idx_q + 2'h1;
          state_q <= (idx_q == last_q) ? S_DONE : S_POPRD;
        end
        S_FETCH:
        begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == last_q)
          begin
            state_q <= S_DONE;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // command capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q <= OP_EA;
      mode_q <= M_REG;
      class_q <= C_OTHER;
      imm_q <= 16'h0000;
      pc_q <= 16'h0000;
      regAddr_q <= 8'h00;
      rdBase_q <= 8'h00;
      pair_q <= 1'b0;
      rfIdx_q <= 1'b0;
      long_q <= 1'b0;
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
      buf_q[2] <= 8'h00;
    end
    else if (accept)
    begin
      op_q <= cmdOp;
      mode_q <= cmdMode;
      class_q <= cmdClass;
      imm_q <= cmdImm;
      pc_q <= pcIn;
      regAddr_q <= regAddr;
      long_q <= cmdLong;
      rfIdx_q <= (cmdClass == C_LOAD);
      pair_q <= (cmdMode == M_IDX) ? isTableClass : cmdPair;
      if (cmdMode == M_IDX)
      begin
        rdBase_q <= isTableClass ? {workAddr[7:1], 1'b0} : workAddr;
      end
      else
      begin
        rdBase_q <= cmdPair ? pairAddr : regAddr;
      end
      buf_q[0] <= (cmdOp == OP_PUSH) ? pushData : pcIn[7:0];
      buf_q[1] <= pcIn[15:8];
      buf_q[2] <= flagsIn;
    end
  end

  // byte accumulators: pops and register fetches arrive high byte first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      popAcc_q <= 24'h000000;
      fetchAcc_q <= 16'h0000;
    end
    else if (accept)
    begin
      popAcc_q <= 24'h000000;
      fetchAcc_q <= 16'h0000;
    end
    else if (state_q == S_POPCAP)
    begin
      popAcc_q <= {popAcc_q[15:0], rfRdData};
    end
    else if (state_q == S_FETCH)
    begin
      fetchAcc_q <= {fetchAcc_q[7:0], rfRdData};
    end
  end

  // ==========================================
  // register file and stack pointer drive
  always_comb
  begin
    rfAddr = 8'h00;
    rfWrEn = 1'b0;
    rfRdEn = 1'b0;
    rfWrData = buf_q[idx_q];
    spc.dec = 1'b0;
    spc.inc = 1'b0;
    case (state_q)
      S_PUSH:
      begin
        rfAddr = spc.value - 8'h01;
        rfWrEn = 1'b1;
        spc.dec = 1'b1;
      end
      S_POPRD:
      begin
        rfAddr = spc.value;
        rfRdEn = 1'b1;
      end
      S_POPCAP:
      begin
        spc.inc = 1'b1;
      end
      S_FETCH:
      begin
        rfAddr = rdBase_q | {7'h00, idx_q[0]};
        rfRdEn = 1'b1;
      end
      default:
      begin
        rfAddr = 8'h00;
      end
    endcase
  end

  // ==========================================
  // results, valid in the done cycle; modeError one cycle after a refused command
  assign doneValid = (state_q == S_DONE);
  assign popData = popAcc_q[7:0];
  assign flagsOut = popAcc_q[23:16];
  assign flagsLoad = doneValid && (op_q == OP_INTRTN);
  assign operand = (op_q == OP_EA && mode_q == M_IMM) ? imm_q[7:0] : 8'h00;
  assign modeError = err_q;

  always_comb
  begin
    pcLoad = 1'b0;
    pcOut = imm_q;
    effAddr = {ZERO_PAGE, spc.value};
    if ((op_q == OP_SUBRTN) || (op_q == OP_INTRTN))
    begin
      pcLoad = doneValid;
      pcOut = popAcc_q[15:0];
    end
    else if (op_q == OP_CALL)
    begin
      pcLoad = doneValid;
    end
    else if (op_q == OP_EA)
    begin
      case (mode_q)
        M_REG: effAddr = {ZERO_PAGE, regAddr_q};
        M_IND: effAddr = pair_q ? fetched : {ZERO_PAGE, rfRdData};
        M_IDX: effAddr = rfIdx_q ? {ZERO_PAGE, imm_q[7:0] + rfRdData} : idxSum;
        M_DIRECT:
        begin
          effAddr = imm_q;
          pcLoad = doneValid && ((class_q == C_AJUMP) || (class_q == C_CALL));
        end
        M_REL:
        begin
          effAddr = relSum;
          pcOut = relSum;
          pcLoad = doneValid;
        end
        default: effAddr = 16'h0000;
      endcase
    end
  end

  // ==========================================
  // APB slave
  assign ptrSel = (paddr == STKPTR_ADDR);
  assign statusSel = (paddr == STATUS_ADDR);
  assign pready = !(ptrSel && busy);
  assign access = psel && penable && pready;
  assign pslverr = psel && penable && !ptrSel && !statusSel;
  assign prdata = prdata_q;
  assign spc.load = access && pwrite && ptrSel && pstrb[0];
  assign spc.loadData = pwdata[7:0];

  always_comb
  begin
    readMux = 32'h0000_0000;
    if (ptrSel)
    begin
      readMux = {24'h000000, spc.value};
    end
    else if (statusSel)
    begin
      readMux[STATUS_BUSY_BIT] = busy;
      readMux[STATUS_ERR_BIT] = errSticky_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (psel && !access)
    begin
      prdata_q <= readMux;
    end
  end

  // sticky mode error, a new error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      errSticky_q <= STATUS_RESET[STATUS_ERR_BIT];
    end
    else if (err_q)
    begin
      errSticky_q <= 1'b1;
    end
    else if (access && pwrite && statusSel && pstrb[0] && pwdata[STATUS_ERR_BIT])
    begin
      errSticky_q <= 1'b0;
    end
  end

endmodule

// File: addr_stack_pkg.sv
// constants and types shared by the operand address and stack unit
package addr_stack_pkg;

  // ==========================================
  // register map (printed location is an index, byte address is four times it)
  localparam logic [7:0] STKPTR_INDEX = 8'hd9;
  localparam logic [7:0] STATUS_INDEX = 8'h00;
  localparam logic [11:0] STKPTR_ADDR = {2'b00, STKPTR_INDEX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_INDEX, 2'b00};
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ERR_BIT = 1;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // ==========================================
  // register file layout
  localparam logic [3:0] WORK_BASE = 4'hc;
  localparam logic [7:0] ZERO_PAGE = 8'h00;

  // ==========================================
  // sequencer counts (last byte index of each sequence)
  localparam logic [1:0] LAST_ONE = 2'h0;
  localparam logic [1:0] LAST_TWO = 2'h1;
  localparam logic [1:0] LAST_THREE = 2'h2;

  typedef enum logic [2:0] {
    OP_PUSH = 3'h0,
    OP_POP = 3'h1,
    OP_CALL = 3'h2,
    OP_SUBRTN = 3'h3,
    OP_INTR = 3'h4,
    OP_INTRTN = 3'h5,
    OP_EA = 3'h6
  } op_t;

  typedef enum logic [2:0] {
    M_REG = 3'h0,
    M_IND = 3'h1,
    M_IDX = 3'h2,
    M_DIRECT = 3'h3,
    M_REL = 3'h4,
    M_IMM = 3'h5
  } mode_t;

  typedef enum logic [2:0] {
    C_OTHER = 3'h0,
    C_LOAD = 3'h1,
    C_PLOAD = 3'h2,
    C_ELOAD = 3'h3,
    C_AJUMP = 3'h4,
    C_CALL = 3'h5,
    C_RJUMP = 3'h6
  } class_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_PUSH = 6'h02,
    S_POPRD = 6'h04,
    S_POPCAP = 6'h08,
    S_FETCH = 6'h10,
    S_DONE = 6'h20
  } state_t;

endpackage

// File: sp_ctrl_if.sv
// stack pointer control signals between the sequencer and the pointer register
`timescale 1ns/1ps
interface sp_ctrl_if;
  logic [7:0] value;
  logic dec;
  logic inc;
  logic load;
  logic [7:0] loadData;

  modport owner (input dec, input inc, input load, input loadData, output value);
  modport user (output dec, output inc, output load, output loadData, input value);
endinterface

// File: stack_pointer.sv
// eight-bit stack pointer register with wrapping step
`timescale 1ns/1ps
module stack_pointer (
  input wire logic clk,
  sp_ctrl_if.owner ctl
);

  logic [7:0] ptr_q;

  // no reset: content is undefined until software loads it
  always_ff @(posedge clk)
  begin
    if (ctl.load)
    begin
      ptr_q <= ctl.loadData;
    end
    else if (ctl.dec)
    begin
      ptr_q <= ptr_q - 8'h01;
    end
    else if (ctl.inc)
    begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  assign ctl.value = ptr_q;

endmodule

// File: offset_adder.sv
// adds a sign-extended offset to a 16-bit base address
`timescale 1ns/1ps
module offset_adder #(
  parameter int OW = 8
) (
  input wire logic [15:0] base,
  input wire logic [OW-1:0] offset,
  output logic [15:0] sum
);

  assign sum = base + 16'($signed(offset));

endmodule

// File: oas_checker.sv
// concurrent checks on the operand address and stack unit ports
`timescale 1ns/1ps
module oas_checker
  import addr_stack_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire op_t cmdOp,
  input wire mode_t cmdMode,
  input wire class_t cmdClass,
  input wire logic [15:0] cmdImm,
  input wire logic [15:0] pcIn,
  input wire logic [7:0] flagsIn,
  input wire logic [7:0] rfAddr,
  input wire logic rfWrEn,
  input wire logic [7:0] rfWrData,
  input wire logic rfRdEn,
  input wire logic doneValid,
  input wire logic [7:0] operand,
  input wire logic pcLoad,
  input wire logic [15:0] pcOut,
  input wire logic modeError
);
  logic [15:0] relTarget_q;
  logic [7:0] immLow_q;
  wire logic take = cmdValid && cmdReady;
  wire logic eaTake = take && cmdOp == OP_EA;
  // ==========================================
  // expected values one cycle on
  always_ff @(posedge clk)
  begin
    relTarget_q <= pcIn + {{8{cmdImm[7]}}, cmdImm[7:0]};
    immLow_q <= cmdImm[7:0];
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // assertions
  chk_unmapped_err: assert property (
    psel && penable && paddr != 12'h000 && paddr != STKPTR_ADDR |-> pslverr)
    else $error("unmapped access without error");
  chk_push_step: assert property (
    rfWrEn && $past(rfWrEn) |-> rfAddr == $past(rfAddr) - 8'h01)
    else $error("push address did not step down");
  chk_pop_step: assert property (
    rfRdEn && $past(rfRdEn, 2) && !$past(rfRdEn) |-> rfAddr == $past(rfAddr, 2) + 8'h01)
    else $error("pop address did not step up");
  chk_pair_order: assert property (
    rfRdEn && $past(rfRdEn) |-> rfAddr[0] && rfAddr == $past(rfAddr) + 8'h01)
    else $error("pair low byte not at next odd address");
  chk_call_target: assert property (
    take && cmdOp == OP_CALL |-> ##3 doneValid && pcLoad && pcOut == $past(cmdImm, 3))
    else $error("call target wrong");
  chk_intr_flags: assert property (
    take && cmdOp == OP_INTR |-> ##1 rfWrEn [*3] ##0 rfWrData == $past(flagsIn, 3))
    else $error("interrupt push sequence wrong");
  chk_rel_target: assert property (
    eaTake && cmdMode == M_REL && cmdClass == C_RJUMP |=> doneValid && pcOut == relTarget_q)
    else $error("relative target wrong");
  chk_rel_refused: assert property (
    eaTake && cmdMode == M_REL && cmdClass != C_RJUMP |=> modeError && !doneValid)
    else $error("relative mode accepted outside relative jump");
  chk_imm_noaccess: assert property (
    eaTake && cmdMode == M_IMM |=> doneValid && !rfRdEn && operand == immLow_q)
    else $error("immediate operand wrong");
  cover property (take && cmdOp == OP_CALL);
  cover property (take && cmdOp == OP_INTRTN);
  cover property (psel && penable && paddr == STKPTR_ADDR);
endmodule

bind operand_address_and_stack_unit oas_checker chk (.*);

// File: rf_model.sv
// register file model, bytes with one-cycle read latency
`timescale 1ns/1ps
module rf_model (
  input wire logic clk,
  input wire logic [7:0] rfAddr,
  input wire logic rfWrEn,
  input wire logic [7:0] rfWrData,
  input wire logic rfRdEn,
  output logic [7:0] rfRdData
);
  logic [7:0] mem [256];
  initial rfRdData = 8'h00;
  // read data stands one cycle, then toggles so stale data never matches
  always @(posedge clk)
  begin
    if (rfWrEn)
      mem[rfAddr] <= rfWrData;
    if (rfRdEn)
      rfRdData <= mem[rfAddr];
    else
      rfRdData <= ~rfRdData;
  end
endmodule

// File: operand_address_and_stack_unit_tb.sv
// self-checking bench for the operand address and stack unit
`timescale 1ns/1ps
module operand_address_and_stack_unit_tb;
  import addr_stack_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cmdValid = 1'b0, cmdWorking = 1'b0, cmdPair = 1'b0, cmdLong = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, cmdReady, rfWrEn, rfRdEn, doneValid, pcLoad, flagsLoad, modeError;
  logic err, me, flL, pcL;
  op_t cmdOp = OP_PUSH;
  mode_t cmdMode = M_REG;
  class_t cmdClass = C_OTHER;
  logic [7:0] cmdReg = 8'h00, flagsIn = 8'h81, pushData = 8'h5a;
  logic [7:0] rfAddr, rfWrData, rfRdData, operand, popData, flagsOut, opd, popd, flO;
  logic [15:0] cmdImm = 16'h0, pcIn = 16'h0, effAddr, pcOut, eff, pcO;
  int err_count = 0, n_compared = 0;

  operand_address_and_stack_unit uut (.*);
  rf_model rf (.*);

  always #20 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================
  // bus and command drivers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ptrIs(input logic [7:0] v);
    apb(1'b0, STKPTR_ADDR, 32'h0);
    check("stkptr", {24'h0, v}, rd);
  endtask

  task automatic cmd(input op_t o, input mode_t m, input class_t c, input logic [2:0] f,
    input logic [7:0] r, input logic [15:0] imm, input logic [15:0] pc);
    int n;
    n = 0;
    cmdOp <= o;
    cmdMode <= m;
    cmdClass <= c;
    {cmdWorking, cmdPair, cmdLong} <= f;
    cmdReg <= r;
    cmdImm <= imm;
    pcIn <= pc;
    cmdValid <= 1'b1;
    @(posedge clk);
    while (!cmdReady)
      @(posedge clk);
    cmdValid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!doneValid && !modeError && n < 12);
    me = modeError;
    eff = effAddr;
    opd = operand;
    popd = popData;
    pcO = pcOut;
    flO = flagsOut;
    flL = flagsLoad;
    pcL = pcLoad;
  endtask

  // ==========================================
  // tests
  initial
  begin
    rf.mem[8'hc3] = 8'h90;
    rf.mem[8'hc4] = 8'h40;
    rf.mem[8'hc5] = 8'h77;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b1, STKPTR_ADDR, 32'h0000_00b7);
    ptrIs(8'hb7);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    cmd(OP_PUSH, M_REG, C_OTHER, 3'b000, 8'h00, 16'h0, 16'h0);
    check("push", 8'h5a, rf.mem[8'hb6]);
    ptrIs(8'hb6);
    cmd(OP_CALL, M_DIRECT, C_CALL, 3'b000, 8'h00, 16'h0abc, 16'h1234);
    check("call_pc", 16'h0abc, pcO);
    check("call_lo", 8'h34, rf.mem[8'hb5]);
    check("call_hi", 8'h12, rf.mem[8'hb4]);
    cmd(OP_INTR, M_REG, C_OTHER, 3'b000, 8'h00, 16'h0, 16'h2345);
    check("intr_flags", 8'h81, rf.mem[8'hb1]);
    ptrIs(8'hb1);
    cmd(OP_INTRTN, M_REG, C_OTHER, 3'b000, 8'h00, 16'h0, 16'h0);
    check("interrupt_return_op_pc", 16'h2345, pcO);
    check("interrupt_return_op_flags", 8'h81, flO);
    check("interrupt_return_op_fload", 1'b1, flL);
    check("interrupt_return_op_pload", 1'b1, pcL);
    cmd(OP_SUBRTN, M_REG, C_OTHER, 3'b000, 8'h00, 16'h0, 16'h0);
    check("ret_pc", 16'h1234, pcO);
    check("ret_fload", 1'b0, flL);
    cmd(OP_POP, M_REG, C_OTHER, 3'b000, 8'h00, 16'h0, 16'h0);
    check("pop", 8'h5a, popd);
    ptrIs(8'hb7);
    apb(1'b1, STKPTR_ADDR, 32'h0);
    cmd(OP_PUSH, M_REG, C_OTHER, 3'b000, 8'h00, 16'h0, 16'h0);
    ptrIs(8'hff);
    cmd(OP_EA, M_REG, C_LOAD, 3'b100, 8'h03, 16'h0, 16'h0);
    check("work", 16'h00c3, eff);
    cmd(OP_EA, M_IND, C_LOAD, 3'b100, 8'h04, 16'h0, 16'h0);
    check("ind", 16'h0040, eff);
    cmd(OP_EA, M_IND, C_PLOAD, 3'b110, 8'h05, 16'h0, 16'h0);
    check("pair", 16'h4077, eff);
    cmd(OP_EA, M_IDX, C_LOAD, 3'b100, 8'h03, 16'h00f0, 16'h0);
    check("idx_rf", 16'h0080, eff);
    cmd(OP_EA, M_IDX, C_PLOAD, 3'b110, 8'h04, 16'h0080, 16'h0);
    check("idx_short", 16'h3ff7, eff);
    cmd(OP_EA, M_IDX, C_ELOAD, 3'b111, 8'h04, 16'h1000, 16'h0);
    check("idx_long", 16'h5077, eff);
    cmd(OP_EA, M_DIRECT, C_PLOAD, 3'b000, 8'h00, 16'hbeef, 16'h0);
    check("da_prog", 16'hbeef, eff);
    cmd(OP_EA, M_DIRECT, C_ELOAD, 3'b000, 8'h00, 16'h1357, 16'h0);
    check("da_ext", 16'h1357, eff);
    cmd(OP_EA, M_DIRECT, C_AJUMP, 3'b000, 8'h00, 16'h0abc, 16'h0);
    check("da_jump", 16'h0abc, pcO);
    cmd(OP_EA, M_REL, C_RJUMP, 3'b000, 8'h00, 16'h0080, 16'h0100);
    check("rel_back", 16'h0080, pcO);
    cmd(OP_EA, M_REL, C_RJUMP, 3'b000, 8'h00, 16'h007f, 16'h0100);
    check("rel_fwd", 16'h017f, pcO);
    cmd(OP_EA, M_IMM, C_LOAD, 3'b000, 8'h00, 16'h00a5, 16'h0);
    check("imm", 8'ha5, opd);
    cmd(OP_EA, M_REL, C_LOAD, 3'b000, 8'h00, 16'h0010, 16'h0);
    check("rel_bad", 1'b1, me);
    cmd(OP_EA, M_IDX, C_AJUMP, 3'b100, 8'h03, 16'h0010, 16'h0);
    check("idx_bad", 1'b1, me);
    cmd(OP_EA, M_DIRECT, C_LOAD, 3'b000, 8'h00, 16'h0010, 16'h0);
    check("da_bad", 1'b1, me);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check("status_err", 32'h2, rd);
    apb(1'b1, STATUS_ADDR, 32'h2);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check("status_clr", 32'h0, rd);
    wrap_up();
  end

  initial
  begin
    #(40 * 5000);
    err_count++;
    wrap_up();
  end
endmodule
